/* verilog/dcp_regs.vh */
`ifndef DCP_REGS_VH
`define DCP_REGS_VH

// ****************************************************
// Bus select codes
// ****************************************************
`define DCP_SEL_DISPLAY   4'hE
`define DCP_SEL_POINTER   4'hF

// ****************************************************
// Position counter
// ****************************************************
`define DCP_POS_W         3
`define DCP_POS_CLEAR     3'h0
`define DCP_POS_STEP      3'h1

// ****************************************************
// Character data and display queue
// ****************************************************
`define DCP_CHAR_W        8
`define DCP_FIFO_W        11
`define DCP_FIFO_DEPTH    8
`define DCP_FIFO_AW       3

// ****************************************************
// Pin synchroniser
// ****************************************************
`define DCP_BUS_W         14

`endif

/* verilog/dcp_fifo.v */
`timescale 1ns/1ps

// ****************************************************
// Display write queue
// ****************************************************
module dcp_fifo
#(
  parameter WIDTH = 11,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             i_clk,
  input  wire             i_rst_b,
  input  wire [WIDTH-1:0] i_in_data,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire             o_out_valid,
  input  wire             i_out_ready
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Handshake terms, full and empty from the occupancy count
  assign o_in_ready  = (count_q != DEPTH[AW:0]);
  assign o_out_valid = (count_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Storage entries
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : g_ent
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          mem_q[g] <= {WIDTH{1'b0}};
        else if (push && ({{(32-AW){1'b0}}, wr_ptr_q} == g))
          mem_q[g] <= i_in_data;
      end
    end
  endgenerate

  // Pointers and count
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // dcp_fifo

/* verilog/dcp_top.v */
// Summary of operation
// [RQ1] A read while the display select code is present clears the counter, so all three inverted position outputs go high.
// [RQ2] The top inverted position bit enables the left module and the two lower bits pick one of its four characters.
// [RQ3] The first write after a clear lands in the leftmost of the eight positions.
// [RQ4] Each finished character write counts the counter up by one, so the inverted address steps down to 110 after the first; one to a full queue does not.
// [RQ5] Successive writes fill successive positions moving right from the leftmost.
// [RQ6] The host refreshes by selecting the display, doing one read, then exactly eight character writes.
// [RQ7] At the display code a read points left and a write loads a character; a write at the next code loads the pointer.
// [RQ8] The counter may count only while the display code is active, and then the shared module enable is asserted.
// [RQ9] After every eighth write without a clear the counter wraps to zero by natural counting.
// [RQ10] The counter advances on the trailing edge of the write strobe so the address holds during the write.
`timescale 1ns/1ps
`include "dcp_regs.vh"

module dcp_top
(
  input  wire                   I_SYS_CLK,
  input  wire                   I_RST_B,
  input  wire [3:0]             I_BUS_SEL,
  input  wire                   I_BUS_RD_N,
  input  wire                   I_BUS_WR_N,
  input  wire [`DCP_CHAR_W-1:0] I_BUS_DATA,
  input  wire                   I_DISP_READY,
  output wire                   O_BUS_WAIT,
  output wire [`DCP_POS_W-1:0]  O_CHAR_POSITION_N,
  output wire                   O_MODULE_ENABLE_N,
  output wire                   O_DISP_WR,
  output wire [`DCP_CHAR_W-1:0] O_DISP_DATA,
  output wire                   O_CHAR_SELECT_LSB,
  output wire                   O_CHAR_SELECT_MSB,
  output wire                   O_LEFT_CE,
  output wire                   O_RIGHT_CE
);

  // ****************************************************
  // Declarations
  // ****************************************************
  wire [`DCP_BUS_W-1:0]  bus_raw;
  reg  [`DCP_BUS_W-1:0]  sync1_q;
  reg  [`DCP_BUS_W-1:0]  sync2_q;
  reg  [`DCP_BUS_W-1:0]  sync3_q;
  reg  [`DCP_BUS_W-1:0]  filt_q;
  wire [3:0]             sel_f;
  wire                   rd_n_f;
  wire                   wr_n_f;
  wire [`DCP_CHAR_W-1:0] data_f;
  reg                    rd_n_prev_q;
  reg                    wr_n_prev_q;
  wire                   rd_start;
  wire                   wr_end;
  wire                   sel_display;
  wire                   sel_pointer;
  reg  [`DCP_POS_W-1:0]  char_position_counter_q;
  reg  [`DCP_POS_W-1:0]  char_position_counter_d;
  reg  [`DCP_POS_W-1:0]  pos_n_q;
  reg                    module_enable_n_q;
  reg                    bus_wait_q;
  wire                   push_valid;
  wire                   push_ready;
  wire [`DCP_FIFO_W-1:0] push_data;
  wire [`DCP_FIFO_W-1:0] pop_data;
  wire                   pop_valid;
  wire                   pop;
  reg                    disp_wr_q;
  reg  [`DCP_CHAR_W-1:0] disp_data_q;
  reg  [`DCP_POS_W-1:0]  disp_pos_n_q;
  reg                    right_ce_q;

  // ****************************************************
  // Pin synchroniser and agreement filter
  // ****************************************************

  // Pins gathered into one vector
  assign bus_raw = {I_BUS_SEL, I_BUS_RD_N, I_BUS_WR_N, I_BUS_DATA};

  // Three stages per pin; the filtered value follows once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `DCP_BUS_W; g = g + 1)
    begin : g_sync
      always @(posedge I_SYS_CLK or negedge I_RST_B)
      begin
        if (!I_RST_B)
        begin
          sync1_q[g] <= 1'b1;
          sync2_q[g] <= 1'b1;
          sync3_q[g] <= 1'b1;
          filt_q[g]  <= 1'b1;
        end
        else
        begin
          sync1_q[g] <= bus_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g])
            filt_q[g] <= sync3_q[g];
        end
      end
    end
  endgenerate

  // Filtered fields
  assign sel_f  = filt_q[13:10];
  assign rd_n_f = filt_q[9];
  assign wr_n_f = filt_q[8];
  assign data_f = filt_q[7:0];

  // ****************************************************
  // Strobe edges and select decode
  // ****************************************************

  // Previous strobe levels for edge detection
  always @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rd_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
    end
    else
    begin
      rd_n_prev_q <= rd_n_f;
      wr_n_prev_q <= wr_n_f;
    end
  end

  // Read leading edge, write trailing edge
  assign rd_start    = rd_n_prev_q & ~rd_n_f;
  assign wr_end      = ~wr_n_prev_q & wr_n_f;                        // RQ10
  assign sel_display = (sel_f == `DCP_SEL_DISPLAY);                  // RQ8
  assign sel_pointer = (sel_f == `DCP_SEL_POINTER);

  // ****************************************************
  // Character position counter
  // ****************************************************

  // Character write queued with the address it was written to
  assign push_valid = wr_end & sel_display;                          // RQ7
  assign push_data  = {~char_position_counter_q, data_f};            // RQ3

  // Next count: clear on read, step on accepted write, load at pointer code
  always @*
  begin
    char_position_counter_d = char_position_counter_q;
    if (rd_start && sel_display)
      char_position_counter_d = `DCP_POS_CLEAR;                      // RQ1
    else if (push_valid && push_ready)
      char_position_counter_d = char_position_counter_q + `DCP_POS_STEP; // RQ4 RQ5 RQ9
    else if (wr_end && sel_pointer)
      char_position_counter_d = data_f[`DCP_POS_W-1:0];              // RQ7
  end

  // Counter and its inverted image on the pins
  always @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      char_position_counter_q <= `DCP_POS_CLEAR;
      pos_n_q                 <= ~`DCP_POS_CLEAR;
    end
    else
    begin
      char_position_counter_q <= char_position_counter_d;
      pos_n_q                 <= ~char_position_counter_d;          // RQ1 RQ4
    end
  end

  // Shared module enable and bus wait
  always @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      module_enable_n_q <= 1'b1;
      bus_wait_q        <= 1'b0;
    end
    else
    begin
      module_enable_n_q <= ~sel_display;                             // RQ8
      bus_wait_q        <= ~push_ready;
    end
  end

  // ****************************************************
  // Display write queue
  // ****************************************************
  dcp_fifo
  #(
    .WIDTH (`DCP_FIFO_W),
    .DEPTH (`DCP_FIFO_DEPTH),
    .AW    (`DCP_FIFO_AW)
  )
  u_fifo
  (
    .i_clk       (I_SYS_CLK),
    .i_rst_b     (I_RST_B),
    .i_in_data   (push_data),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .o_out_data  (pop_data),
    .o_out_valid (pop_valid),
    .i_out_ready (I_DISP_READY)
  );

  assign pop = pop_valid & I_DISP_READY;

  // ****************************************************
  // Display write port
  // ****************************************************

  // One-cycle write pulse with data and inverted address held until the next
  always @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      disp_wr_q    <= 1'b0;
      disp_data_q  <= {`DCP_CHAR_W{1'b0}};
      disp_pos_n_q <= ~`DCP_POS_CLEAR;
      right_ce_q   <= 1'b0;
    end
    else
    begin
      disp_wr_q <= pop;
      if (pop)
      begin
        disp_data_q  <= pop_data[`DCP_CHAR_W-1:0];
        disp_pos_n_q <= pop_data[`DCP_FIFO_W-1:`DCP_CHAR_W];
        right_ce_q   <= ~pop_data[`DCP_FIFO_W-1];                    // RQ2
      end
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign O_BUS_WAIT        = bus_wait_q;
  assign O_CHAR_POSITION_N = pos_n_q;
  assign O_MODULE_ENABLE_N = module_enable_n_q;
  assign O_DISP_WR         = disp_wr_q;
  assign O_DISP_DATA       = disp_data_q;
  assign O_CHAR_SELECT_LSB = disp_pos_n_q[0];                        // RQ2
  assign O_CHAR_SELECT_MSB = disp_pos_n_q[1];                        // RQ2
  assign O_LEFT_CE         = disp_pos_n_q[2];                        // RQ2
  assign O_RIGHT_CE        = right_ce_q;                             // RQ2

endmodule // dcp_top

/* dv/dcp_props.sv */
`timescale 1ns/1ps
// ****************************************************
// Position counter and display write port checker
// ****************************************************
module dcp_props
(
  input wire       I_SYS_CLK,
  input wire       I_RST_B,
  input wire [3:0] I_BUS_SEL,
  input wire       I_BUS_RD_N,
  input wire       I_BUS_WR_N,
  input wire       I_DISP_READY,
  input wire       O_BUS_WAIT,
  input wire [2:0] O_CHAR_POSITION_N,
  input wire       O_MODULE_ENABLE_N,
  input wire       O_DISP_WR,
  input wire [7:0] O_DISP_DATA,
  input wire       O_LEFT_CE,
  input wire       O_RIGHT_CE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  reg [2:0] exp_q;
  // Position expected once a write strobe ends
  always @(posedge I_SYS_CLK or negedge I_RST_B)
    if (!I_RST_B) exp_q <= 3'h7;
    else if ($rose(I_BUS_WR_N)) exp_q <= O_CHAR_POSITION_N - 3'h1;
  sequence s_clear; $fell(I_BUS_RD_N) && I_BUS_SEL == 4'hE; endsequence
  sequence s_write; $rose(I_BUS_WR_N) && I_BUS_SEL == 4'hE && !O_BUS_WAIT; endsequence
  AST_CLEAR: assert property (s_clear |-> ##[1:8] O_CHAR_POSITION_N == 3'h7)
    else $error("clear missed");
  AST_STEP: assert property (s_write |-> ##[1:8] O_CHAR_POSITION_N == exp_q)
    else $error("step missed");
  AST_HOLD_WR: assert property (!I_BUS_WR_N && !$past(I_BUS_WR_N) |-> $stable(O_CHAR_POSITION_N))
    else $error("position moved in write");
  AST_EN_ON: assert property (I_BUS_SEL == 4'hE [*8] |-> !O_MODULE_ENABLE_N)
    else $error("enable missing");
  AST_OTHER: assert property ((I_BUS_SEL != 4'hE && I_BUS_SEL != 4'hF) [*8] |-> $stable(O_CHAR_POSITION_N))
    else $error("count at other code");
  AST_WRAP: assert property ($past(O_CHAR_POSITION_N) == 3'h0 && $changed(O_CHAR_POSITION_N) && I_BUS_SEL == 4'hE |-> O_CHAR_POSITION_N == 3'h7)
    else $error("wrap wrong");
  AST_CE: assert property (O_DISP_WR |-> O_RIGHT_CE == !O_LEFT_CE)
    else $error("enables clash");
  AST_STALL: assert property (!I_DISP_READY |=> !O_DISP_WR)
    else $error("write while stalled");
  AST_DATA_HOLD: assert property (!O_DISP_WR |-> $stable(O_DISP_DATA))
    else $error("data not held");
endmodule // dcp_props

bind dcp_top dcp_props chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_BUS_SEL(I_BUS_SEL),
  .I_BUS_RD_N(I_BUS_RD_N), .I_BUS_WR_N(I_BUS_WR_N), .I_DISP_READY(I_DISP_READY),
  .O_BUS_WAIT(O_BUS_WAIT), .O_CHAR_POSITION_N(O_CHAR_POSITION_N),
  .O_MODULE_ENABLE_N(O_MODULE_ENABLE_N), .O_DISP_WR(O_DISP_WR), .O_DISP_DATA(O_DISP_DATA),
  .O_LEFT_CE(O_LEFT_CE), .O_RIGHT_CE(O_RIGHT_CE));

/* dv/dcp_disp_model.sv */
`timescale 1ns/1ps
// Display module model: logs each character with its address
module dcp_disp_model
(
  input  wire       i_clk,
  input  wire       i_stall,
  input  wire       i_wr,
  input  wire [7:0] i_data,
  input  wire       i_left_ce,
  input  wire       i_msb,
  input  wire       i_lsb,
  output wire       o_ready
);
  reg     [10:0] log_q [0:31];
  integer        n_got = 0;
  assign o_ready = !i_stall;
  always @(posedge i_clk)
    if (i_wr)
    begin
      log_q[n_got[4:0]] <= {i_left_ce, i_msb, i_lsb, i_data};
      n_got <= n_got + 1;
    end
endmodule // dcp_disp_model

/* dv/display_char_position_counter_test.sv */
`timescale 1ns/1ps
module display_char_position_counter_test;
  reg        clk = 1'b0;
  reg        rst_b = 1'b0;
  reg  [3:0] sel = 4'hC;
  reg        rd_n = 1'b1;
  reg        wr_n = 1'b1;
  reg  [7:0] data = 8'h00;
  reg        stall = 1'b0;
  reg  [2:0] e3;
  reg  [7:0] ch;
  wire       ready, bus_wait, en_n, disp_wr, lsb, msb, left_ce, right_ce;
  wire [2:0] pos_n;
  wire [7:0] disp_data;
  integer    n_errors = 0;
  integer    total_checks = 0;
  integer    i, base;
  always #20 clk = ~clk;
  dcp_top dut_u (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_BUS_SEL(sel), .I_BUS_RD_N(rd_n),
    .I_BUS_WR_N(wr_n), .I_BUS_DATA(data), .I_DISP_READY(ready), .O_BUS_WAIT(bus_wait),
    .O_CHAR_POSITION_N(pos_n), .O_MODULE_ENABLE_N(en_n), .O_DISP_WR(disp_wr),
    .O_DISP_DATA(disp_data), .O_CHAR_SELECT_LSB(lsb), .O_CHAR_SELECT_MSB(msb),
    .O_LEFT_CE(left_ce), .O_RIGHT_CE(right_ce));
  dcp_disp_model disp_u (.i_clk(clk), .i_stall(stall), .i_wr(disp_wr), .i_data(disp_data),
    .i_left_ce(left_ce), .i_msb(msb), .i_lsb(lsb), .o_ready(ready));
  task chk(input string nm, input [10:0] exp, input [10:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #2;
    end
  endtask
  // One bus access: select, strobe low, strobe high, settle
  task bus(input [3:0] s, input w, input [7:0] d);
    begin
      sel = s;
      data = d;
      tick(6);
      if (w) wr_n = 1'b0;
      else rd_n = 1'b0;
      tick(6);
      wr_n = 1'b1;
      rd_n = 1'b1;
      tick(8);
    end
  endtask
  task t_refresh;
    begin
      base = disp_u.n_got;
      bus(4'hE, 1'b0, 8'h00);
      chk("pos_clear", 3'h7, pos_n);
      for (i = 0; i < 8; i = i + 1)
      begin
        bus(4'hE, 1'b1, 8'h41 + i);
        e3 = ~(i + 1);
        chk("pos_step", e3, pos_n);
        chk("right_ce", (i >= 4), right_ce);
      end
      for (i = 0; i < 8; i = i + 1)
      begin
        e3 = ~i;
        ch = 8'h41 + i;
        chk("disp_slot", {e3, ch}, disp_u.log_q[base + i]);
      end
    end
  endtask
  task t_pointer;
    begin
      bus(4'hF, 1'b1, 8'h05);
      chk("pos_load", 3'h2, pos_n);
      bus(4'hF, 1'b0, 8'h00);
      chk("pos_rd_f", 3'h2, pos_n);
      bus(4'hE, 1'b1, 8'h5A);
      chk("pos_after_load", 3'h1, pos_n);
      bus(4'hC, 1'b1, 8'h00);
      chk("pos_other", 3'h1, pos_n);
      chk("en_off", 1'b1, en_n);
      bus(4'hE, 1'b0, 8'h00);
      chk("pos_clear2", 3'h7, pos_n);
      chk("en_on", 1'b0, en_n);
    end
  endtask
  // Queue filled while the display stalls, then drained
  task t_full;
    begin
      base = disp_u.n_got;
      stall = 1'b1;
      for (i = 0; i < 8; i = i + 1)
        bus(4'hE, 1'b1, 8'h30 + i);
      chk("wait_full", 1'b1, bus_wait);
      bus(4'hE, 1'b1, 8'h7E);
      chk("pos_drop", 3'h7, pos_n);
      stall = 1'b0;
      tick(20);
      chk("wait_empty", 1'b0, bus_wait);
      chk("drained", 11'h8, disp_u.n_got - base);
      chk("drain_first", {3'h7, 8'h30}, disp_u.log_q[base]);
      chk("drain_last", {3'h0, 8'h37}, disp_u.log_q[base + 7]);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    tick(12);
    rst_b = 1'b1;
    tick(2);
    t_refresh;
    t_pointer;
    t_full;
    print_verdict;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule // display_char_position_counter_test
